// File: core/cpt_top.sv
// Purpose: Clock prescaler control and oscillator trim registers on APB
// Assumes: Fuse and calibration inputs are static around reset
// Notes: Zero wait states; unmapped addresses read zero, no error
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module cpt_top
  import cpt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic div8_start_fuse_i,
  input wire logic [6:0] factory_cal_i,
  output logic [6:0] osc_trim_o,
  output logic sys_tick_o,
  output logic sys_clk_o
);
  // ============================================================
  // Input synchronisers for static pins
  logic fuse_s1_reg, fuse_s2_reg;
  logic [6:0] cal_s1_reg, cal_s2_reg;

  // Two stage capture
  always_ff @(posedge core_clk_i) begin
    fuse_s1_reg <= div8_start_fuse_i;
    fuse_s2_reg <= fuse_s1_reg;
    cal_s1_reg <= factory_cal_i;
    cal_s2_reg <= cal_s1_reg;
  end

  // ============================================================
  // Register state
  logic unlock_reg, unlock_next; // Change unlock flag
  logic [2:0] win_reg, win_next; // Cycles left in window
  logic [3:0] sel_reg, sel_next; // Prescale select
  logic [6:0] trim_reg, trim_next; // Oscillator trim
  logic [31:0] rdata_reg, rdata_next;
  logic wr_en, rd_en, hit_pre, hit_trim;

  // Address decode on the full byte address
  function automatic logic addr_is(input logic [11:0] a, input logic [9:0] b);
    addr_is = (a[11:10] == 2'b00) && (a[9:0] == b);
  endfunction

  always_comb begin
    hit_pre = addr_is(paddr_i, CPT_PRESCALE_ADDR);
    hit_trim = addr_is(paddr_i, CPT_TRIM_ADDR);
    wr_en = psel_i & penable_i & pwrite_i;
    rd_en = psel_i & ~penable_i & ~pwrite_i;
  end

  // ============================================================
  // Next values for the control registers
  always_comb begin
    unlock_next = unlock_reg;
    win_next = win_reg;
    sel_next = sel_reg;
    trim_next = trim_reg;
    // R7: timed expiry of unlock
    if (unlock_reg) begin
      win_next = win_reg - 3'h1;
      if (win_reg == 3'h1) begin
        unlock_next = 1'b0;
      end
    end
    if (wr_en && hit_pre) begin
      if (pwdata_i[CPT_UNLOCK_BIT]) begin
        // R6: only with other bits zero
        // R8: rewrite keeps running window
        if (pwdata_i[CPT_UNLOCK_BIT-1:0] == 7'h00 && !unlock_reg) begin
          unlock_next = 1'b1;
          win_next = CPT_UNLOCK_CYCLES;
        end
      end else begin
        // R10: select taken only when unlocked
        // R13: any code, fuse ignored
        if (unlock_reg) begin
          sel_next = pwdata_i[CPT_SEL_W-1:0];
        end
        // R7: select write ends window
        unlock_next = 1'b0;
        win_next = 3'h0;
      end
    end
    // R2: monotonic code stored as is
    if (wr_en && hit_trim) begin
      trim_next = pwdata_i[CPT_TRIM_W-1:0];
    end
  end

  // Read data capture in setup phase
  always_comb begin
    rdata_next = CPT_ZERO_WORD;
    if (rd_en && hit_pre) begin
      // R9: bits six to four zero
      // R18: divider count not visible
      rdata_next = {24'h00_0000, unlock_reg, 3'b000, sel_reg};
    end else if (rd_en && hit_trim) begin
      // R1: top trim bit reads zero
      rdata_next = {24'h00_0000, 1'b0, trim_reg};
    end else if (psel_i && penable_i) begin
      rdata_next = rdata_reg;
    end
  end

  // Registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      unlock_reg <= 1'b0;
      win_reg <= 3'h0;
      // R12: fuse picks reset select
      // R19: fuse sampled during reset
      sel_reg <= fuse_s2_reg ? CPT_SEL_RST_DIV8 : CPT_SEL_RST_DIV1;
      // R3: calibration loaded at reset
      trim_reg <= cal_s2_reg;
      rdata_reg <= CPT_ZERO_WORD;
    end else begin
      unlock_reg <= unlock_next;
      win_reg <= win_next;
      sel_reg <= sel_next;
      trim_reg <= trim_next;
      rdata_reg <= rdata_next;
    end
  end

  // ============================================================
  // Divider; R14: reserved codes clamp at 256
  logic [3:0] sel_eff;
  always_comb begin
    sel_eff = (sel_reg > CPT_SEL_MAX) ? CPT_SEL_MAX : sel_reg;
  end

  cpt_divider #(.CNT_W(8)) u_div (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .sel_i(sel_eff),
    .tick_o(sys_tick_o),
    .div_clk_o(sys_clk_o)
  );

  // Bus answers
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign prdata_o = rdata_reg;
  assign osc_trim_o = trim_reg;
endmodule

// File: common/cpt_pkg.sv
// Purpose: Constants for the clock prescaler and oscillator trim block
// Assumes: APB slave, 32-bit data, one word per register
// Notes: Contract list follows
// Contract
// R1: Trim bit seven reads zero always
// R2: Trim code raises frequency monotonically
// R3: Reset loads factory calibration into trim
// R4: Software keeps trim within ten percent
// R5: Software steps trim at most 0x20
// R6: Unlock sets only with other bits zero
// R7: Unlock clears after four cycles or select write
// R8: Rewrite of unlock neither restarts nor clears
// R9: Prescale bits six to four read zero
// R10: Select accepted only while unlocked
// R11: Software disables interrupts during sequence
// R12: Reset select from divide-by-eight fuse
// R13: Any select value accepted after reset
// R14: Codes zero to eight divide by power of two
// R15: Divided clock feeds processor and peripherals
// R16: Division change glitch free, no short period
// R17: New rate within old plus two new periods
// R18: Divider runs from master clock, unreadable
// R19: Fuse sampled in reset; reserved codes unspecified
// ============================================================
// Package
package cpt_pkg;
  // Offsets printed are not multiples of four: indices, byte address is 4x
  localparam logic [7:0] CPT_PRESCALE_IDX = 8'h26;
  localparam logic [7:0] CPT_TRIM_IDX = 8'h31;
  localparam logic [9:0] CPT_PRESCALE_ADDR = {CPT_PRESCALE_IDX, 2'b00};
  localparam logic [9:0] CPT_TRIM_ADDR = {CPT_TRIM_IDX, 2'b00};
  // Field positions
  localparam int CPT_UNLOCK_BIT = 7;
  localparam int CPT_SEL_W = 4;
  localparam int CPT_TRIM_W = 7;
  // Reset select values and top select code
  localparam logic [3:0] CPT_SEL_RST_DIV1 = 4'h0;
  localparam logic [3:0] CPT_SEL_RST_DIV8 = 4'h3;
  localparam logic [3:0] CPT_SEL_MAX = 4'h8;
  // Unlock window in master clock cycles
  localparam logic [2:0] CPT_UNLOCK_CYCLES = 3'h4;
  localparam logic [31:0] CPT_ZERO_WORD = 32'h0000_0000;
endpackage

// File: core/cpt_divider.sv
// Purpose: Glitch-free power-of-two clock divider
// Assumes: Runs on the undivided master clock
// Notes: Emits a one-cycle enable pulse at the divided rate
`timescale 1ns/10ps
module cpt_divider
  import cpt_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] sel_i,
  output logic tick_o,
  output logic div_clk_o
);
  // ============================================================
  // Counter state
  logic [CNT_W-1:0] cnt_reg, cnt_next; // Period counter, cleared at period end, not visible to software
  logic [3:0] act_reg, act_next; // Division in force
  logic tick_reg, tick_next;
  logic clk_reg, clk_next;
  logic [CNT_W-1:0] mask;

  // Terminal mask for a given code
  function automatic logic [CNT_W-1:0] term_mask(input logic [3:0] s);
    logic [CNT_W:0] one;
    one = {{CNT_W{1'b0}}, 1'b1} << s;
    term_mask = one[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
  endfunction

  // ============================================================
  // Next state
  always_comb begin
    mask = term_mask(act_reg);
    cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    act_next = act_reg;
    tick_next = 1'b0;
    clk_next = clk_reg;
    // R16: change only at period end
    if ((cnt_reg & mask) == mask) begin
      tick_next = 1'b1;
      // R17: new rate after current period
      act_next = sel_i;
      cnt_next = '0;
      clk_next = 1'b1;
    end else if ((cnt_reg & mask) == (mask >> 1)) begin
      clk_next = (act_reg == 4'h0);
    end else if (act_reg == 4'h0) begin
      clk_next = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cnt_reg <= '0;
      act_reg <= CPT_SEL_RST_DIV1;
      tick_reg <= 1'b0;
      clk_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      act_reg <= act_next;
      tick_reg <= tick_next;
      clk_reg <= clk_next;
    end
  end

  // R15: enable goes out to the processor and peripherals; the registers here run every master cycle
  assign tick_o = tick_reg;
  assign div_clk_o = clk_reg;
endmodule

// File: tb/cpt_asserts.sv
// Purpose: Port checks for cpt_top
// Assumes: Zero wait APB slave
// Notes: Bound after the module
`timescale 1ns/10ps
module cpt_asserts
  import cpt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [6:0] osc_trim_o,
  input wire logic sys_tick_o,
  input wire logic sys_clk_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // Access phase decode
  wire acc = psel_i && penable_i;
  wire to_pre = paddr_i == 12'(CPT_PRESCALE_ADDR);
  wire to_trm = paddr_i == 12'(CPT_TRIM_ADDR);
  wire wr_trm = acc && pwrite_i && to_trm;
  wire rd_pre = acc && !pwrite_i && to_pre;
  // Unlock write taken
  sequence s_unl;
    acc && pwrite_i && to_pre && pwdata_i == 32'h0000_0080;
  endsequence
  AST_READY:
  assert property (acc |-> pready_o && !pslverr_o) else $error("bad bus answer");
  AST_TRIM_WR:
  assert property (wr_trm |=> osc_trim_o == $past(pwdata_i[6:0])) else $error("trim not taken");
  AST_TRIM_HOLD:
  assert property (!wr_trm |=> $stable(osc_trim_o)) else $error("trim moved");
  AST_TRIM_RD:
  assert property (acc && !pwrite_i && to_trm |-> prdata_o[31:7] == 0) else $error("trim msb");
  AST_PRE_RD:
  assert property (rd_pre |-> prdata_o[31:8] == 0 && prdata_o[6:4] == 0) else $error("rsvd");
  AST_UNLOCK_RD:
  assert property (s_unl ##2 rd_pre |-> prdata_o[7]) else $error("unlock not set");
  AST_TICK_CLK:
  assert property (sys_tick_o |-> sys_clk_o) else $error("tick without clock");
  AST_TICK_DUE:
  assert property (!sys_tick_o |-> ##[1:800] sys_tick_o) else $error("tick late");
endmodule
bind cpt_top cpt_asserts i_cpt_asserts (.core_clk_i, .reset_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .osc_trim_o,
  .sys_tick_o, .sys_clk_o);

// File: tb/test_clock_prescaler_trim.sv
// Purpose: Self-checking bench for cpt_top
// Assumes: APB master, seed 25
// Notes: Random trim steps and calibration
`timescale 1ns/10ps
module test_clock_prescaler_trim import cpt_pkg::*; ();
  localparam logic [11:0] PRE = 12'(CPT_PRESCALE_ADDR);
  localparam logic [11:0] TRM = 12'(CPT_TRIM_ADDR);
  logic core_clk_i = 0, reset_i = 1, psel = 0, pen = 0, pwr = 0, fuse = 0;
  logic [11:0] padr = 0;
  logic [31:0] pwd = 0, rd;
  logic [6:0] cal = 0, t;
  wire [31:0] prd;
  wire rdy, tick;
  wire [6:0] trim;
  int bad_count = 0, checks = 0, cyc = 0, p;
  always #4 core_clk_i = ~core_clk_i;
  cpt_top i_cpt_top (.core_clk_i, .reset_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(),
    .div8_start_fuse_i(fuse), .factory_cal_i(cal), .osc_trim_o(trim), .sys_tick_o(tick),
    .sys_clk_o());
  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One APB transfer, request held until ready
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge core_clk_i);
    pen <= 1;
    do @(posedge core_clk_i); while (rdy !== 1'b1);
    rd = prd;
  endtask
  task automatic idle(input int n);
    psel <= 0;
    pen <= 0;
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic rst(input logic f);
    reset_i <= 1;
    fuse <= f;
    cal <= 7'($urandom);
    repeat (20) @(posedge core_clk_i);
    reset_i <= 0;
    @(posedge core_clk_i);
    chk(32'(trim), 32'(cal));
    xf(0, PRE, 0);
    idle(1);
    chk(rd, f ? 32'h0000_0003 : 32'h0000_0000);
  endtask
  // Two-write change, kept uninterrupted
  task automatic setsel(input logic [3:0] s);
    xf(1, PRE, 32'h0000_0080);
    xf(1, PRE, 32'(s));
    xf(0, PRE, 0);
    idle(1);
    chk(rd, 32'(s));
  endtask
  task automatic meas(output int n);
    repeat (3) @(posedge core_clk_i iff tick === 1'b1);
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (tick !== 1'b1);
  endtask
  function automatic int per(input int c);
    return 1 << c;
  endfunction
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc > 30000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    void'($urandom(25));
    rst(0);
    rst(1);
    for (int c = 0; c <= 8; c++) begin
      setsel(4'(c));
      meas(p);
      chk(p, per(c));
    end
    setsel(0);
    xf(1, PRE, 32'h0000_0080);
    xf(1, PRE, 32'h0000_0075);
    xf(0, PRE, 0);
    chk(rd, 32'h0000_0005);
    setsel(0);
    xf(1, PRE, 32'h0000_0081);
    xf(1, PRE, 32'h0000_0002);
    xf(0, PRE, 0);
    chk(rd, 0);
    xf(1, PRE, 32'h0000_0080);
    idle(4);
    xf(1, PRE, 32'h0000_0002);
    xf(0, PRE, 0);
    chk(rd, 0);
    xf(1, PRE, 32'h0000_0080);
    xf(1, PRE, 32'h0000_0080);
    xf(0, PRE, 0);
    chk(rd, 32'h0000_0080);
    xf(0, PRE, 0);
    chk(rd, 0);
    t = trim;
    repeat (6) begin
      t = t ^ 7'($urandom_range(31));
      xf(1, TRM, {24'h00_0000, 1'b1, t});
      xf(0, TRM, 0);
      chk(rd, 32'(t));
      chk(32'(trim), 32'(t));
    end
    xf(1, 12'h004, 32'hFFFF_FFFF);
    xf(0, 12'h004, 0);
    idle(1);
    chk(rd, 0);
    results();
  end
endmodule
